//--- common/hall_rotor_regs.svh
// register offsets, field positions, reset values and constants of the rotor position block
`ifndef HALL_ROTOR_REGS_SVH
`define HALL_ROTOR_REGS_SVH
`define ADDR_CTRL        8'h00
`define ADDR_HALL_DELAY  8'h04
`define ADDR_TICK_CYCLES 8'h08
`define ADDR_ENC_STEP    8'h0c
`define ADDR_ALIGN_CFG   8'h10
`define ADDR_STATUS      8'h14
`define ADDR_ANGLE       8'h18
`define ADDR_SPEED       8'h1c
`define ADDR_PERIOD      8'h20
`define ADDR_ENC_COUNT   8'h24
`define CTRL_COMBINE     0
`define CTRL_ENC_MODE    1
`define CTRL_DISP60      2
`define CTRL_ALIGN_GO    3
`define TICK_CYCLES_RST  16'h03e8
`define ENC_STEP_RST     16'h0010
`define SIXTY_DEG        16'h2aab
`define THIRTY_DEG       16'h1555
`define PERIOD_LOW       16'h0400
`define PSC_MAX          4'hf
`define ALIGN_RAMP_STEP  16'h0010
`define ALIGN_MAG_MAX    16'h4000
`endif

//--- common/hall_rotor_pkg.sv
// types shared by the rotor position block
package hall_rotor_pkg;
	typedef enum logic {ALIGN_IDLE, ALIGN_RAMP} align_state_type;
	typedef logic [15:0] angle_type;
endpackage

//--- verilog/hall_encoder_rotor_position.sv
// hall / quadrature rotor position and speed block with apb registers
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hall_rotor_regs.svh"

// Functional notes
// - combine mode xors three hall inputs
// - speed from combined signal period
// - hall state is third-second-first bits
// - direction from state versus previous state
// - direction read from individual hall inputs
// - keep resolution over 1:1000 period range
// - short captures lower the prescaler
// - overflow between captures raises prescaler
// - new prescaler applies from next capture
// - every combined edge resyncs angle
// - angle error corrects new speed, no jump
// - add speed step each control tick
// - 120 or 60 degree sensor displacement
// - hall position absolute, no prepositioning
// - configured delay added as angle offset
// - quadrature counter gives angle and direction
// - angle in signed sixteen bit unit
// - encoder needs alignment after reset/fault
// - alignment: fixed orientation, ramping magnitude
// - alignment end loads encoder counter
// - encoder speed is angle difference
module hall_encoder_rotor_position
	import hall_rotor_pkg::*;
(
	input  wire logic        MCLK_IN,
	input  wire logic        SRST_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	input  wire logic        HALL_INPUT_FIRST_IN,
	input  wire logic        HALL_INPUT_SECOND_IN,
	input  wire logic        HALL_INPUT_THIRD_IN,
	input  wire logic        QUADRATURE_INPUT_A_IN,
	input  wire logic        QUADRATURE_INPUT_B_IN,
	input  wire logic        CTRL_TICK_IN,
	input  wire logic        FAULT_IN,
	output logic      [15:0] ANGLE_OUT,
	output logic      [15:0] SPEED_OUT,
	output logic             DIR_NEG_OUT,
	output logic             ANGLE_VALID_OUT,
	output logic             ALIGN_ACTIVE_OUT,
	output logic      [15:0] FLUX_ANGLE_OUT,
	output logic      [15:0] FLUX_MAG_OUT
);
	// config registers
	logic [3:0]      ctrl_q;
	logic [15:0]     delay_q;
	logic [15:0]     tick_cycles_q;
	logic [15:0]     enc_step_q;
	logic [31:0]     align_cfg_q;
	// pin synchronisers
	logic [4:0]      sync1_q;
	logic [4:0]      sync2_q;
	// hall path
	logic [2:0]      hall_state;
	logic [2:0]      prev_state_q;
	logic            comb;
	logic            comb_prev_q;
	logic            edge_seen;
	logic            dir_neg_q;
	logic [2:0]      sec_now;
	logic [2:0]      sec_prev;
	angle_type       sector_base;
	angle_type       hall_angle;
	// capture timer
	logic [3:0]      psc_act_q;
	logic [3:0]      psc_buf_q;
	logic [14:0]     pre_cnt_q;
	logic [15:0]     cnt_q;
	logic            ovf_q;
	logic            first_q;
	logic [15:0]     period_q;
	logic            pre_tick;
	// divider
	logic            div_busy_q;
	logic [5:0]      div_cnt_q;
	logic [31:0]     div_rem_q;
	logic [31:0]     div_quo_q;
	logic [31:0]     div_den_q;
	logic [32:0]     div_trial;
	logic signed [16:0] numer;
	logic [15:0]     speed_mag_q;
	angle_type       hall_ang_q;
	// encoder path
	logic [1:0]      qab_prev_q;
	logic [15:0]     enc_cnt_q;
	angle_type       enc_angle;
	angle_type       enc_prev_q;
	logic [15:0]     enc_speed_q;
	logic            aligned_q;
	align_state_type align_st_q;
	logic [15:0]     flux_mag_q;
	logic            apb_wr;
	logic            apb_acc;

	// sector index along the positive sequence of either sensor spacing
	function automatic logic [2:0] sector(input logic [2:0] st, input logic d60);
		logic [2:0] r;
		r = 3'h0;
		if (d60) begin
			case (st)
				3'h1: r = 3'h1;
				3'h3: r = 3'h2;
				3'h7: r = 3'h3;
				3'h6: r = 3'h4;
				3'h4: r = 3'h5;
				default: r = 3'h0;
			endcase
		end else begin
			case (st)
				3'h1: r = 3'h1;
				3'h3: r = 3'h2;
				3'h2: r = 3'h3;
				3'h6: r = 3'h4;
				3'h4: r = 3'h5;
				default: r = 3'h0;
			endcase
		end
		return r;
	endfunction

	// two flops on every hall and quadrature pin before use; wiring order assumed per sensor number
	always_ff @(posedge MCLK_IN) begin
		if (SRST_IN) begin
			sync1_q <= 5'h00;
			sync2_q <= 5'h00;
		end else begin
			sync1_q <= {QUADRATURE_INPUT_B_IN, QUADRATURE_INPUT_A_IN, HALL_INPUT_THIRD_IN,
				HALL_INPUT_SECOND_IN, HALL_INPUT_FIRST_IN};
			sync2_q <= sync1_q;
		end
	end

	// hall decode from the individual sensor levels
	assign hall_state  = sync2_q[2:0];
	assign comb        = ctrl_q[`CTRL_COMBINE] ? ^sync2_q[2:0] : sync2_q[0];
	assign edge_seen   = comb ^ comb_prev_q;
	assign sec_now     = sector(hall_state, ctrl_q[`CTRL_DISP60]);
	assign sec_prev    = sector(prev_state_q, ctrl_q[`CTRL_DISP60]);
	assign sector_base = 16'({13'h0000, sec_now} * `SIXTY_DEG);
	// edge position: sector start going forward, sector end going backward
	assign hall_angle  = sector_base + delay_q + (dir_neg_q ? `SIXTY_DEG : 16'h0000);

	// direction from sector step; state memory kept per change
	always_ff @(posedge MCLK_IN) begin
		if (SRST_IN) begin
			prev_state_q <= 3'h0;
			comb_prev_q  <= 1'b0;
			dir_neg_q    <= 1'b0;
		end else begin
			comb_prev_q <= comb;
			if (hall_state != prev_state_q) begin
				prev_state_q <= hall_state;
				if (sec_now == ((sec_prev == 3'h5) ? 3'h0 : sec_prev + 3'h1))
					dir_neg_q <= 1'b0;
				else if (sec_prev == ((sec_now == 3'h5) ? 3'h0 : sec_now + 3'h1))
					dir_neg_q <= 1'b1;
			end
		end
	end

	// prescaled capture timer; prescaler is a power of two
	assign pre_tick = (pre_cnt_q == 15'((16'h0001 << psc_act_q) - 16'h0001));

	always_ff @(posedge MCLK_IN) begin
		if (SRST_IN) begin
			pre_cnt_q <= 15'h0000;
			cnt_q     <= 16'h0000;
			ovf_q     <= 1'b0;
			period_q  <= 16'h0000;
			psc_act_q <= 4'h0;
			psc_buf_q <= 4'h0;
			first_q   <= 1'b1;
		end else if (edge_seen) begin
			pre_cnt_q <= 15'h0000;
			cnt_q     <= 16'h0000;
			ovf_q     <= 1'b0;
			period_q  <= cnt_q;
			first_q   <= 1'b0;
			psc_act_q <= psc_buf_q; // decided last capture, used from now
			// an overflow landing on the capture edge still counts
			if ((ovf_q || (pre_tick && cnt_q == 16'hffff)) && psc_buf_q != `PSC_MAX)
				psc_buf_q <= psc_buf_q + 4'h1;
			else if (!ovf_q && cnt_q < `PERIOD_LOW && psc_buf_q != 4'h0)
				psc_buf_q <= psc_buf_q - 4'h1;
		end else begin
			pre_cnt_q <= pre_tick ? 15'h0000 : pre_cnt_q + 15'h0001;
			if (pre_tick && cnt_q == 16'hffff)
				ovf_q <= 1'b1; // saturate rather than wrap
			else if (pre_tick)
				cnt_q <= cnt_q + 16'h0001;
		end
	end

	// sixty degrees corrected by the resync error, scaled by the tick length
	always_comb begin
		numer = 17'(signed'({1'b0, `SIXTY_DEG}))
			+ (dir_neg_q ? -17'(signed'(hall_angle - ANGLE_OUT)) : 17'(signed'(hall_angle - ANGLE_OUT)));
	end
	assign div_trial = {div_rem_q, div_quo_q[31]} - {1'b0, div_den_q};

	// serial divider, 32 steps; a new edge restarts it with fresh data
	always_ff @(posedge MCLK_IN) begin
		if (SRST_IN) begin
			div_busy_q  <= 1'b0;
			div_cnt_q   <= 6'h00;
			div_rem_q   <= 32'h00000000;
			div_quo_q   <= 32'h00000000;
			div_den_q   <= 32'h00000001;
			speed_mag_q <= 16'h0000;
		end else if (edge_seen) begin
			if (first_q || ovf_q || (pre_tick && cnt_q == 16'hffff)) begin
				speed_mag_q <= 16'h0000;
				div_busy_q  <= 1'b0;
			end else begin
				div_busy_q <= 1'b1;
				div_cnt_q  <= 6'h00;
				div_rem_q  <= 32'h00000000;
				div_quo_q  <= numer[16] ? 32'h00000000 : 32'(numer[15:0] * tick_cycles_q);
				div_den_q  <= 32'({16'h0000, cnt_q} << psc_act_q); // period in clocks
			end
		end else if (ovf_q && psc_act_q == `PSC_MAX && pre_tick && cnt_q == 16'hffff) begin
			speed_mag_q <= 16'h0000;
			div_busy_q  <= 1'b0;
		end else if (div_busy_q) begin
			div_cnt_q <= div_cnt_q + 6'h01;
			if (!div_trial[32]) begin
				div_rem_q <= div_trial[31:0];
				div_quo_q <= {div_quo_q[30:0], 1'b1};
			end else begin
				div_rem_q <= {div_rem_q[30:0], div_quo_q[31]};
				div_quo_q <= {div_quo_q[30:0], 1'b0};
			end
			if (div_cnt_q == 6'h1f) begin
				div_busy_q <= 1'b0;
				speed_mag_q <= (div_quo_q[30:14] != 17'h00000) ? 16'h7fff : {1'b0, div_quo_q[13:0], !div_trial[32]};
			end
		end
	end

	// encoder x4 decode, direction folded into the count
	assign enc_angle = 16'(enc_cnt_q * enc_step_q);

	always_ff @(posedge MCLK_IN) begin
		if (SRST_IN) begin
			qab_prev_q <= 2'h0;
			enc_cnt_q  <= 16'h0000;
		end else begin
			qab_prev_q <= sync2_q[4:3];
			if (align_st_q == ALIGN_RAMP && CTRL_TICK_IN && flux_mag_q >= `ALIGN_MAG_MAX)
				enc_cnt_q <= align_cfg_q[31:16];
			else if ((sync2_q[3] ^ qab_prev_q[0]) != (sync2_q[4] ^ qab_prev_q[1]))
				enc_cnt_q <= (sync2_q[3] ^ qab_prev_q[1]) ? enc_cnt_q + 16'h0001
					: enc_cnt_q - 16'h0001;
		end
	end

	// alignment sequencer; a fault forgets the reference
	always_ff @(posedge MCLK_IN) begin
		if (SRST_IN) begin
			align_st_q <= ALIGN_IDLE;
			flux_mag_q <= 16'h0000;
			aligned_q  <= 1'b0;
		end else if (FAULT_IN) begin
			align_st_q <= ALIGN_IDLE;
			flux_mag_q <= 16'h0000;
			aligned_q  <= 1'b0;
		end else begin
			case (align_st_q)
				ALIGN_IDLE: begin
					flux_mag_q <= 16'h0000;
					if (apb_wr && PADDR_IN == `ADDR_CTRL && PWDATA_IN[`CTRL_ALIGN_GO] && ctrl_q[`CTRL_ENC_MODE]) begin
						align_st_q <= ALIGN_RAMP;
						aligned_q  <= 1'b0;
					end
				end
				ALIGN_RAMP: begin
					if (CTRL_TICK_IN && flux_mag_q >= `ALIGN_MAG_MAX) begin
						align_st_q <= ALIGN_IDLE;
						aligned_q  <= 1'b1;
					end else if (CTRL_TICK_IN)
						flux_mag_q <= flux_mag_q + `ALIGN_RAMP_STEP;
				end
				default: align_st_q <= ALIGN_IDLE;
			endcase
		end
	end

	// angle, speed and direction outputs; hall angle stepped per control tick, encoder angle follows the counter
	always_ff @(posedge MCLK_IN) begin
		if (SRST_IN) begin
			ANGLE_OUT        <= 16'h0000;
			SPEED_OUT        <= 16'h0000;
			DIR_NEG_OUT      <= 1'b0;
			ANGLE_VALID_OUT  <= 1'b0;
			enc_prev_q       <= 16'h0000;
			enc_speed_q      <= 16'h0000;
			hall_ang_q       <= 16'h0000;
		end else if (ctrl_q[`CTRL_ENC_MODE]) begin
			ANGLE_OUT       <= enc_angle;
			ANGLE_VALID_OUT <= aligned_q;
			DIR_NEG_OUT     <= enc_speed_q[15];
			SPEED_OUT       <= enc_speed_q;
			if (CTRL_TICK_IN) begin
				enc_speed_q <= enc_angle - enc_prev_q;
				enc_prev_q  <= enc_angle;
			end
		end else begin
			ANGLE_VALID_OUT <= 1'b1;
			DIR_NEG_OUT     <= dir_neg_q;
			SPEED_OUT       <= dir_neg_q ? 16'h0000 - speed_mag_q : speed_mag_q;
			// no jump on resync: only snap while no speed is known
			if (edge_seen && speed_mag_q == 16'h0000)
				ANGLE_OUT <= hall_angle;
			else if (CTRL_TICK_IN && speed_mag_q == 16'h0000)
				ANGLE_OUT <= sector_base + `THIRTY_DEG + delay_q;
			else if (CTRL_TICK_IN)
				ANGLE_OUT <= dir_neg_q ? ANGLE_OUT - speed_mag_q : ANGLE_OUT + speed_mag_q;
			if (edge_seen)
				hall_ang_q <= hall_angle;
		end
	end

	// flux command follows the alignment sequencer
	always_ff @(posedge MCLK_IN) begin
		if (SRST_IN) begin
			ALIGN_ACTIVE_OUT <= 1'b0;
			FLUX_ANGLE_OUT   <= 16'h0000;
			FLUX_MAG_OUT     <= 16'h0000;
		end else begin
			ALIGN_ACTIVE_OUT <= (align_st_q == ALIGN_RAMP);
			FLUX_ANGLE_OUT   <= align_cfg_q[15:0];
			FLUX_MAG_OUT     <= flux_mag_q;
		end
	end

	// apb slave: one wait state, write lands on the pready edge
	assign apb_acc = PSEL_IN & PENABLE_IN;
	assign apb_wr  = apb_acc & PWRITE_IN & PREADY_OUT;

	always_ff @(posedge MCLK_IN) begin
		if (SRST_IN) begin
			ctrl_q        <= 4'h0;
			delay_q       <= 16'h0000;
			tick_cycles_q <= `TICK_CYCLES_RST;
			enc_step_q    <= `ENC_STEP_RST;
			align_cfg_q   <= 32'h00000000;
		end else if (apb_wr) begin
			if (PADDR_IN == `ADDR_CTRL)
				ctrl_q <= {1'b0, PWDATA_IN[2:0]}; // go bit self clears
			else if (PADDR_IN == `ADDR_HALL_DELAY)
				delay_q <= PWDATA_IN[15:0];
			else if (PADDR_IN == `ADDR_TICK_CYCLES)
				tick_cycles_q <= PWDATA_IN[15:0];
			else if (PADDR_IN == `ADDR_ENC_STEP)
				enc_step_q <= PWDATA_IN[15:0];
			else if (PADDR_IN == `ADDR_ALIGN_CFG)
				align_cfg_q <= PWDATA_IN;
		end
	end

	// read mux and handshake
	always_ff @(posedge MCLK_IN) begin
		if (SRST_IN) begin
			PREADY_OUT  <= 1'b0;
			PRDATA_OUT  <= 32'h00000000;
			PSLVERR_OUT <= 1'b0;
		end else begin
			PREADY_OUT  <= apb_acc & ~PREADY_OUT;
			PSLVERR_OUT <= 1'b0;
			PRDATA_OUT  <= 32'h00000000;
			if (apb_acc && !PREADY_OUT) begin
				if (PADDR_IN == `ADDR_CTRL)
					PRDATA_OUT <= {28'h0000000, ctrl_q};
				else if (PADDR_IN == `ADDR_HALL_DELAY)
					PRDATA_OUT <= {16'h0000, delay_q};
				else if (PADDR_IN == `ADDR_TICK_CYCLES)
					PRDATA_OUT <= {16'h0000, tick_cycles_q};
				else if (PADDR_IN == `ADDR_ENC_STEP)
					PRDATA_OUT <= {16'h0000, enc_step_q};
				else if (PADDR_IN == `ADDR_ALIGN_CFG)
					PRDATA_OUT <= align_cfg_q;
				else if (PADDR_IN == `ADDR_STATUS)
					PRDATA_OUT <= {20'h00000, psc_act_q, 2'h0, align_st_q == ALIGN_RAMP,
						aligned_q, dir_neg_q, hall_state};
				else if (PADDR_IN == `ADDR_ANGLE)
					PRDATA_OUT <= {hall_ang_q, ANGLE_OUT};
				else if (PADDR_IN == `ADDR_SPEED)
					PRDATA_OUT <= {16'h0000, SPEED_OUT};
				else if (PADDR_IN == `ADDR_PERIOD)
					PRDATA_OUT <= {12'h000, psc_buf_q, period_q};
				else if (PADDR_IN == `ADDR_ENC_COUNT)
					PRDATA_OUT <= {16'h0000, enc_cnt_q};
				else
					PSLVERR_OUT <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

//--- dv/hall_rotor_checker_assertions.sv
// assertion checker watching the rotor position block ports
`timescale 1ns/1ps
`default_nettype none
module hall_rotor_checker (
	input wire logic        MCLK_IN,
	input wire logic        SRST_IN,
	input wire logic        PSEL_IN,
	input wire logic        PENABLE_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic        PREADY_OUT,
	input wire logic        PSLVERR_OUT,
	input wire logic        CTRL_TICK_IN,
	input wire logic        FAULT_IN,
	input wire logic        ALIGN_ACTIVE_OUT,
	input wire logic [15:0] FLUX_ANGLE_OUT,
	input wire logic [15:0] FLUX_MAG_OUT
);
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (SRST_IN);
	// bus answer: one wait state, one-cycle pulse, data only with ready
	a_ready_wait: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
		else $error("ready not after one wait state");
	a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("ready held too long");
	a_ready_access: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN)
		else $error("ready outside access phase");
	a_error_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
		else $error("error without ready");
	a_rdata_idle_zero: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
		else $error("read data outside answer");
	// ramp grows by a fixed step on each tick, angle never moves meanwhile
	a_ramp_linear_step: assert property (ALIGN_ACTIVE_OUT && CTRL_TICK_IN && !FAULT_IN && FLUX_MAG_OUT < 16'h4000
		&& !$past(CTRL_TICK_IN) && !$past(FAULT_IN)
		|=> ##1 FLUX_MAG_OUT == $past(FLUX_MAG_OUT) + 16'h0010) else $error("ramp step wrong");
	a_flux_orient_fixed: assert property (ALIGN_ACTIVE_OUT ##1 ALIGN_ACTIVE_OUT |-> $stable(FLUX_ANGLE_OUT))
		else $error("flux angle moved");
	a_idle_mag_zero: assert property (!ALIGN_ACTIVE_OUT ##1 !ALIGN_ACTIVE_OUT |-> FLUX_MAG_OUT == 16'h0)
		else $error("flux magnitude while idle");
	a_fault_stops_align: assert property (FAULT_IN |-> ##[1:2] !ALIGN_ACTIVE_OUT)
		else $error("fault left alignment running");
	c_align_done: cover property ($fell(ALIGN_ACTIVE_OUT));
	c_bus_error: cover property (PSLVERR_OUT);
	c_read_data: cover property (PREADY_OUT && PRDATA_OUT != 32'h0);
endmodule
bind hall_encoder_rotor_position hall_rotor_checker u_chk (
	.MCLK_IN(MCLK_IN), .SRST_IN(SRST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
	.CTRL_TICK_IN(CTRL_TICK_IN), .FAULT_IN(FAULT_IN), .ALIGN_ACTIVE_OUT(ALIGN_ACTIVE_OUT),
	.FLUX_ANGLE_OUT(FLUX_ANGLE_OUT), .FLUX_MAG_OUT(FLUX_MAG_OUT)
);
`default_nettype wire

//--- dv/motor_shaft_model.sv
// hall sensor set and quadrature encoder on the motor shaft
`timescale 1ns/1ps
`default_nettype none
module motor_shaft_model (
	input  wire logic clk_in,
	input  wire logic step_in,
	input  wire logic reverse_in,
	input  wire logic disp60_in,
	output logic      hall_first_out,
	output logic      hall_second_out,
	output logic      hall_third_out,
	output logic      quad_a_out,
	output logic      quad_b_out
);
	logic [2:0]  pos_q = 3'h0;
	logic [1:0]  quad_q = 2'h0;
	logic [17:0] seq;
	logic [2:0]  state;
	// one sector per step; speed is set by how often the bench steps
	always_ff @(posedge clk_in) begin
		if (step_in) begin
			pos_q <= reverse_in ? (pos_q == 3'h0 ? 3'h5 : pos_q - 3'h1) : (pos_q == 3'h5 ? 3'h0 : pos_q + 3'h1);
			quad_q <= reverse_in ? quad_q - 2'h1 : quad_q + 2'h1;
		end
	end
	// positive order 5,1,3,2,6,4 or 0,1,3,7,6,4, third sensor on top
	assign seq = disp60_in ? 18'h017f4 : 18'h296b4;
	assign state = seq[17 - 3 * pos_q -: 3];
	assign hall_first_out = state[0];
	assign hall_second_out = state[1];
	assign hall_third_out = state[2];
	// gray count, a leads b when turning forward
	assign quad_a_out = quad_q[1] ^ quad_q[0];
	assign quad_b_out = quad_q[1];
endmodule
`default_nettype wire

//--- dv/hall_encoder_rotor_position_tb.sv
// self-checking bench for the rotor position block
`timescale 1ns/1ps
`default_nettype none
`include "hall_rotor_regs.svh"
module hall_encoder_rotor_position_tb;
	logic        clk, rst, psel, pen, pwr, tick, fault, step, rev, d60, perr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, h1, h2, h3, qa, qb, dneg, valid, aact;
	logic [15:0] angle, speed, fang, fmag, a0;
	int          err_total, tests_run;

	hall_encoder_rotor_position dut (.MCLK_IN(clk), .SRST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .HALL_INPUT_FIRST_IN(h1), .HALL_INPUT_SECOND_IN(h2), .HALL_INPUT_THIRD_IN(h3),
		.QUADRATURE_INPUT_A_IN(qa), .QUADRATURE_INPUT_B_IN(qb), .CTRL_TICK_IN(tick), .FAULT_IN(fault),
		.ANGLE_OUT(angle), .SPEED_OUT(speed), .DIR_NEG_OUT(dneg), .ANGLE_VALID_OUT(valid),
		.ALIGN_ACTIVE_OUT(aact), .FLUX_ANGLE_OUT(fang), .FLUX_MAG_OUT(fmag));
	motor_shaft_model shaft (.clk_in(clk), .step_in(step), .reverse_in(rev), .disp60_in(d60),
		.hall_first_out(h1), .hall_second_out(h2), .hall_third_out(h3), .quad_a_out(qa), .quad_b_out(qb));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", w, exp, seen);
		end
	endtask

	// setup, access, hold until ready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
		apb(1'b0, a, 32'h0);
		chk(w, rd & m, e);
	endtask

	// gap sets the shaft speed: one sector every gap+1 clocks
	task automatic turn(input int n, input int gap);
		repeat (n) begin
			step <= 1'b1;
			@(posedge clk);
			step <= 1'b0;
			repeat (gap) @(posedge clk);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
			@(posedge clk);
		end
	endtask

	task automatic tally_and_finish();
		if (err_total == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// hang guard, about a sixth above the expected run of some 77000 clocks
	initial begin
		#4500000;
		err_total++;
		tally_and_finish();
	end

	initial begin
		{psel, pen, pwr, tick, fault, step, rev, d60} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		err_total = 0;
		tests_run = 0;
		rst = 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rdchk(`ADDR_TICK_CYCLES, 32'hffff, {16'h0, `TICK_CYCLES_RST}, "tick_cycles");
		rdchk(`ADDR_ENC_STEP, 32'hffff, {16'h0, `ENC_STEP_RST}, "enc_step");
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped_err", {31'h0, perr}, 32'h1);
		chk("unmapped_data", rd, 32'h0);
		// combined hall edges every 201 clocks, then turn back
		apb(1'b1, `ADDR_CTRL, 32'h1);
		turn(13, 200);
		chk("valid", {31'h0, valid}, 32'h1);
		rdchk(`ADDR_STATUS, 32'hf, 32'h1, "state_fwd");
		rdchk(`ADDR_PERIOD, 32'hffff, 32'h00c8, "period_201");
		chk("period_201_range", {31'h0, rd[15:0] > 16'd195 && rd[15:0] < 16'd207}, 32'h1);
		chk("speed_fwd", {31'h0, speed != 16'h0 && !speed[15]}, 32'h1);
		// one control tick moves the angle by exactly one speed step
		a0 = angle;
		ticks(1);
		chk("angle_step", {16'h0, angle}, {16'h0, 16'(a0 + speed)});
		rev <= 1'b1;
		turn(3, 200);
		rev <= 1'b0;
		rdchk(`ADDR_STATUS, 32'hf, 32'he, "state_rev");
		chk("dir_neg", {31'h0, dneg}, 32'h1);
		// uncombined: first sensor alone toggles every third sector
		apb(1'b1, `ADDR_CTRL, 32'h0);
		turn(7, 200);
		apb(1'b0, `ADDR_PERIOD, 32'h0);
		chk("period_603_range", {31'h0, rd[15:0] > 16'd597 && rd[15:0] < 16'd609}, 32'h1);
		// long stall overflows the counter, then fast edges again
		apb(1'b1, `ADDR_CTRL, 32'h1);
		turn(6, 200);
		repeat (66000) @(posedge clk);
		turn(1, 60);
		rdchk(`ADDR_PERIOD, 32'hf0000, 32'h10000, "psc_buffered_up");
		rdchk(`ADDR_STATUS, 32'hf00, 32'h0, "psc_active_old");
		chk("speed_overflow", {16'h0, speed}, 32'h0);
		turn(1, 60);
		rdchk(`ADDR_STATUS, 32'hf00, 32'h100, "psc_active_new");
		turn(6, 200);
		rdchk(`ADDR_PERIOD, 32'hf0000, 32'h0, "psc_down");
		// sixty degree sensor set
		d60 <= 1'b1;
		apb(1'b1, `ADDR_CTRL, 32'h5);
		turn(8, 200);
		rdchk(`ADDR_STATUS, 32'hf, 32'h7, "state_60");
		// encoder: alignment ramp, counter preset, counting both ways
		apb(1'b1, `ADDR_CTRL, 32'h2);
		repeat (2) @(posedge clk);
		chk("enc_not_aligned", {31'h0, valid}, 32'h0);
		apb(1'b1, `ADDR_ALIGN_CFG, 32'h0100_1234);
		apb(1'b1, `ADDR_CTRL, 32'ha);
		repeat (2) @(posedge clk);
		chk("align_active", {31'h0, aact}, 32'h1);
		chk("flux_angle", {16'h0, fang}, 32'h1234);
		ticks(1026);
		chk("aligned", {30'h0, aact, valid}, 32'h1);
		rdchk(`ADDR_ENC_COUNT, 32'hffff, 32'h0100, "enc_preset");
		repeat (4) begin
			turn(1, 4);
			ticks(1);
		end
		rdchk(`ADDR_ENC_COUNT, 32'hffff, 32'h0104, "enc_fwd");
		chk("enc_speed", {16'h0, speed}, {16'h0, `ENC_STEP_RST});
		rev <= 1'b1;
		turn(6, 10);
		rev <= 1'b0;
		ticks(1);
		rdchk(`ADDR_ENC_COUNT, 32'hffff, 32'h00fe, "enc_rev");
		chk("enc_dir_neg", {31'h0, dneg}, 32'h1);
		fault <= 1'b1;
		repeat (2) @(posedge clk);
		fault <= 1'b0;
		@(posedge clk);
		chk("fault_unaligned", {31'h0, valid}, 32'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
